// [hw/timer8_output_compare_ctc.sv]
// top: 8-bit timer with two compare channels, normal and clear-on-match modes, APB slave
//
// Contract
// - match flag set one tick after equality
// - flag and enable raise channel interrupt
// - flag clears on service or written one
// - pwm modes buffered, others immediate
// - buffered value loads at top/bottom only
// - cpu reaches buffer or active register
// - force strobe acts on output only
// - counter write blocks next tick's match
// - output action unbuffered, next match
// - reset clears compare output registers
// - nonzero action overrides port value
// - action zero leaves output unchanged
// - outputs kept across mode change
// - only mode bits shape counting
// - mode 0 counts up, wraps
// - normal overflow flag set at zero
// - mode 2 clears after match A
// - low compare A wraps through max
// - toggle action on channel A
// - prescale 1,8,64,256,1024
// - ctc overflow set at max to zero, except on a match A clear
// - select zero stops counting
// - cpu write beats hardware count
`timescale 1ns/1ps
module timer8_output_compare_ctc (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic overflowAck,
	input wire logic matchAckA,
	input wire logic matchAckB,
	output logic overflowIrq,
	output logic matchIrqA,
	output logic matchIrqB,
	output logic pinOutA,
	output logic pinOutB,
	output logic pinOeA,
	output logic pinOeB
);
	timer8_pkg::control_t control;
	logic [7:0] counterValue;
	logic [7:0] compareValueA;
	logic [7:0] compareValueB;
	logic [7:0] bufferA;
	logic [7:0] bufferB;
	logic overflowFlag;
	logic matchFlagA;
	logic matchFlagB;
	logic [2:0] irqEnable;
	logic [3:0] pins;
	logic compareOutputA;
	logic compareOutputB;
	logic [9:0] prescale;
	logic timerTick;
	logic blockMatch;
	logic pendA;
	logic pendB;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic wrEn;
	logic access;
	logic [2:0] waveformModeSelect;
	logic pwmMode;
	logic matchA;
	logic matchB;
	logic forceA;
	logic forceB;
	logic wrCounter;
	logic [7:0] wbyte;
	logic mapped;

	assign access = psel && penable && !pready;
	assign wrEn = access && pwrite && pstrb[0];
	assign wbyte = pwdata[7:0];
	assign waveformModeSelect = control.waveformModeSelect[2:0];
	// only 0 and 2 are non-pwm here
	assign pwmMode = (waveformModeSelect != timer8_pkg::WGM_NORMAL)
		&& (waveformModeSelect != timer8_pkg::WGM_CTC);
	assign wrCounter = wrEn && (paddr == timer8_pkg::OFF_COUNTER);
	assign forceA = wrEn && (paddr == timer8_pkg::OFF_FORCE) && wbyte[0] && !pwmMode;
	assign forceB = wrEn && (paddr == timer8_pkg::OFF_FORCE) && wbyte[1] && !pwmMode;
	assign matchA = timerTick && !blockMatch && (counterValue == compareValueA);
	assign matchB = timerTick && !blockMatch && (counterValue == compareValueB);
	assign mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);

	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	logic [9:0] divTop;
	always_comb
	begin
		case (control.clockSourceSelect)
			3'h2: divTop = timer8_pkg::DIV_8;
			3'h3: divTop = timer8_pkg::DIV_64;
			3'h4: divTop = timer8_pkg::DIV_256;
			3'h5: divTop = timer8_pkg::DIV_1024;
			default: divTop = 10'h000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst || control.clockSourceSelect == 3'h0)
		begin
			prescale <= 10'h000;
			timerTick <= 1'b0;
		end
		else if (control.clockSourceSelect > 3'h5)
		begin
			// external sources not present: treated as stopped
			prescale <= 10'h000;
			timerTick <= 1'b0;
		end
		else if (prescale >= divTop)
		begin
			prescale <= 10'h000;
			timerTick <= 1'b1;
		end
		else
		begin
			prescale <= prescale + 10'h001;
			timerTick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// match blocking after counter write
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			blockMatch <= 1'b0;
		else if (wrCounter)
			blockMatch <= 1'b1;
		else if (timerTick)
			blockMatch <= 1'b0;
	end

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			counterValue <= timer8_pkg::RST_BYTE;
		else if (wrCounter)
			counterValue <= wbyte;
		else if (timerTick)
		begin
			// sequence depends on mode bits only, never on output action
			if (waveformModeSelect == timer8_pkg::WGM_CTC && matchA && !blockMatch)
				counterValue <= timer8_pkg::RST_BYTE;
			else
				counterValue <= counterValue + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// compare registers, buffered in pwm modes
	// ------------------------------------------------------------
	logic atTopOrBottom;
	assign atTopOrBottom = timerTick && (counterValue == timer8_pkg::MAX_COUNT);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			compareValueA <= timer8_pkg::RST_BYTE;
			compareValueB <= timer8_pkg::RST_BYTE;
			bufferA <= timer8_pkg::RST_BYTE;
			bufferB <= timer8_pkg::RST_BYTE;
		end
		else
		begin
			if (wrEn && paddr == timer8_pkg::OFF_CMP_A)
			begin
				if (pwmMode)
					bufferA <= wbyte;
				else
				begin
					compareValueA <= wbyte;
					bufferA <= wbyte;
				end
			end
			else if (pwmMode && atTopOrBottom)
				compareValueA <= bufferA;
			if (wrEn && paddr == timer8_pkg::OFF_CMP_B)
			begin
				if (pwmMode)
					bufferB <= wbyte;
				else
				begin
					compareValueB <= wbyte;
					bufferB <= wbyte;
				end
			end
			else if (pwmMode && atTopOrBottom)
				compareValueB <= bufferB;
		end
	end

	// ------------------------------------------------------------
	// flags: match flags set on the tick after the match, overflow on its own tick, set wins over clear
	// ------------------------------------------------------------
	logic clrWrite;
	logic ovfEvent;
	assign clrWrite = wrEn && (paddr == timer8_pkg::OFF_FLAGS);
	assign ovfEvent = timerTick && !wrCounter && counterValue == timer8_pkg::MAX_COUNT
		&& !(waveformModeSelect == timer8_pkg::WGM_CTC && matchA);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pendA <= 1'b0;
			pendB <= 1'b0;
		end
		else
		begin
			if (matchA)
				pendA <= 1'b1;
			else if (timerTick)
				pendA <= 1'b0;
			if (matchB)
				pendB <= 1'b1;
			else if (timerTick)
				pendB <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			matchFlagA <= 1'b0;
			matchFlagB <= 1'b0;
			overflowFlag <= 1'b0;
		end
		else
		begin
			if (pendA && timerTick)
				matchFlagA <= 1'b1;
			else if (matchAckA || (clrWrite && wbyte[timer8_pkg::FLG_MA]))
				matchFlagA <= 1'b0;
			if (pendB && timerTick)
				matchFlagB <= 1'b1;
			else if (matchAckB || (clrWrite && wbyte[timer8_pkg::FLG_MB]))
				matchFlagB <= 1'b0;
			if (ovfEvent)
				overflowFlag <= 1'b1;
			else if (overflowAck || (clrWrite && wbyte[timer8_pkg::FLG_OVF]))
				overflowFlag <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			matchIrqA <= 1'b0;
			matchIrqB <= 1'b0;
			overflowIrq <= 1'b0;
		end
		else
		begin
			matchIrqA <= matchFlagA && irqEnable[timer8_pkg::FLG_MA];
			matchIrqB <= matchFlagB && irqEnable[timer8_pkg::FLG_MB];
			overflowIrq <= overflowFlag && irqEnable[timer8_pkg::FLG_OVF];
		end
	end

	// ------------------------------------------------------------
	// compare output registers
	// ------------------------------------------------------------
	function automatic logic applyAction(input logic [1:0] com, input logic cur);
		case (com)
			timer8_pkg::COM_TOGGLE: applyAction = !cur;
			timer8_pkg::COM_CLEAR: applyAction = 1'b0;
			timer8_pkg::COM_SET: applyAction = 1'b1;
			default: applyAction = cur;
		endcase
	endfunction

	// mode changes never touch these, so state survives them
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			compareOutputA <= 1'b0;
			compareOutputB <= 1'b0;
		end
		else
		begin
			// action read live, so a new setting applies at the next match
			if ((matchA && !pwmMode) || forceA)
				compareOutputA <= applyAction(control.comA, compareOutputA);
			if ((matchB && !pwmMode) || forceB)
				compareOutputB <= applyAction(control.comB, compareOutputB);
		end
	end

	// ------------------------------------------------------------
	// pin override
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pinOutA <= 1'b0;
			pinOutB <= 1'b0;
			pinOeA <= 1'b0;
			pinOeB <= 1'b0;
		end
		else
		begin
			pinOutA <= (control.comA != timer8_pkg::COM_NONE) ? compareOutputA
				: pins[timer8_pkg::PIN_PORT_A];
			pinOutB <= (control.comB != timer8_pkg::COM_NONE) ? compareOutputB
				: pins[timer8_pkg::PIN_PORT_B];
			pinOeA <= pins[timer8_pkg::PIN_DIR_A];
			pinOeB <= pins[timer8_pkg::PIN_DIR_B];
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			control <= '0;
			irqEnable <= 3'h0;
			pins <= 4'h0;
		end
		else if (wrEn)
		begin
			if (paddr == timer8_pkg::OFF_CONTROL)
			begin
				control <= pwdata[11:0];
				control.pad <= 1'b0;
			end
			if (paddr == timer8_pkg::OFF_IRQ_EN)
				irqEnable <= wbyte[2:0];
			if (paddr == timer8_pkg::OFF_PINS)
				pins <= wbyte[3:0];
		end
	end

	// ------------------------------------------------------------
	// apb answer: one wait state, pready one cycle
	// ------------------------------------------------------------
	logic [31:0] rdMux;
	always_comb
	begin
		rdMux = 32'h0000_0000;
		case (paddr)
			timer8_pkg::OFF_CONTROL: rdMux = {20'h00000, control};
			timer8_pkg::OFF_COUNTER: rdMux = {24'h000000, counterValue};
			timer8_pkg::OFF_CMP_A: rdMux = {24'h000000, pwmMode ? bufferA : compareValueA};
			timer8_pkg::OFF_CMP_B: rdMux = {24'h000000, pwmMode ? bufferB : compareValueB};
			timer8_pkg::OFF_FLAGS: rdMux = {29'h00000000, matchFlagB, matchFlagA, overflowFlag};
			timer8_pkg::OFF_IRQ_EN: rdMux = {29'h00000000, irqEnable};
			timer8_pkg::OFF_PINS: rdMux = {26'h0000000, compareOutputB, compareOutputA, pins};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= access;
			pslverr <= access && !mapped;
			prdata <= (access && !pwrite) ? rdMux : 32'h0000_0000;
		end
	end
endmodule // timer8_output_compare_ctc

// [hw/timer8_pkg.sv]
// package: register map, field layout and mode codes of the 8-bit compare timer
package timer8_pkg;
	// register byte offsets on APB
	localparam logic [11:0] OFF_CONTROL = 12'h000;
	localparam logic [11:0] OFF_COUNTER = 12'h004;
	localparam logic [11:0] OFF_CMP_A = 12'h008;
	localparam logic [11:0] OFF_CMP_B = 12'h00C;
	localparam logic [11:0] OFF_FLAGS = 12'h010;
	localparam logic [11:0] OFF_IRQ_EN = 12'h014;
	localparam logic [11:0] OFF_FORCE = 12'h018;
	localparam logic [11:0] OFF_PINS = 12'h01C;
	// control field positions
	localparam int CTL_WGM_LSB = 0;
	localparam int CTL_CS_LSB = 4;
	localparam int CTL_COMA_LSB = 8;
	localparam int CTL_COMB_LSB = 10;
	// flag bit positions
	localparam int FLG_OVF = 0;
	localparam int FLG_MA = 1;
	localparam int FLG_MB = 2;
	// pins register fields
	localparam int PIN_PORT_A = 0;
	localparam int PIN_PORT_B = 1;
	localparam int PIN_DIR_A = 2;
	localparam int PIN_DIR_B = 3;
	// reset value and counter top
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] MAX_COUNT = 8'hFF;
	// waveform modes
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_CTC = 3'h2;
	// output action codes
	localparam logic [1:0] COM_NONE = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	// prescale divider terminal counts (factor minus one)
	localparam logic [9:0] DIV_8 = 10'h007;
	localparam logic [9:0] DIV_64 = 10'h03F;
	localparam logic [9:0] DIV_256 = 10'h0FF;
	localparam logic [9:0] DIV_1024 = 10'h3FF;

	typedef struct packed {
		logic [1:0] comB;
		logic [1:0] comA;
		logic pad;
		logic [2:0] clockSourceSelect;
		logic [3:0] waveformModeSelect;
	} control_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage

// [verif/pin_load.sv]
// partner: load on a compare pin, counts level changes
`timescale 1ns/1ps
module pin_load (
	input wire logic clk,
	input wire logic pinOut,
	input wire logic pinOe,
	output logic line,
	output int edges
);
	logic last = 1'b0;
	int count = 0;
	// released pin falls to the pull-down
	assign line = pinOe ? pinOut : 1'b0;
	assign edges = count;
	always @(posedge clk)
	begin
		if (line != last)
			count <= count + 1;
		last <= line;
	end
endmodule // pin_load

// [verif/timer8_chk.sv]
// checker: port assertions for the 8-bit compare timer
`timescale 1ns/1ps
module timer8_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic overflowAck,
	input wire logic matchAckA,
	input wire logic matchAckB,
	input wire logic overflowIrq,
	input wire logic matchIrqA,
	input wire logic matchIrqB,
	input wire logic pinOutA,
	input wire logic pinOutB,
	input wire logic pinOeA,
	input wire logic pinOeB
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_reset_outs;
		disable iff (1'b0) rst |=> !pinOutA && !pinOutB && !pinOeA && !pinOeB && !overflowIrq;
	endproperty
	a_reset_outs: assert property (p_reset_outs) else $error("outputs not clear after reset");
	property p_access_len;
		psel && penable && !pready |=> pready;
	endproperty
	a_access_len: assert property (p_access_len) else $error("no ready after access");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	property p_rdata_idle;
		!pready |-> prdata == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	property p_err_unmapped;
		psel && penable && !pready && paddr >= 12'h020 |=> pslverr && prdata == 32'h00000000;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_oe_cause;
		$changed(pinOeA) |-> $past(psel && pwrite && paddr == timer8_pkg::OFF_PINS)
			|| $past(psel && pwrite && paddr == timer8_pkg::OFF_PINS, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("direction moved on its own");
	property p_irq_fall;
		$fell(overflowIrq) |-> $past(overflowAck) || $past(overflowAck, 2)
			|| $past(overflowAck, 3) || $past(psel && pwrite, 2) || $past(psel && pwrite, 3);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without clear");
endmodule // timer8_chk

bind timer8_output_compare_ctc timer8_chk i_chk (.clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .overflowAck, .matchAckA,
	.matchAckB, .overflowIrq, .matchIrqA, .matchIrqB, .pinOutA, .pinOutB, .pinOeA, .pinOeB);

// [verif/timer8_output_compare_ctc_bench.sv]
// bench: self-checking scenarios for the 8-bit compare timer
`timescale 1ns/1ps
module timer8_output_compare_ctc_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic overflowAck = 1'b0;
	logic matchAckA = 1'b0;
	logic matchAckB = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, overflowIrq, matchIrqA, matchIrqB, err;
	logic pinOutA, pinOutB, pinOeA, pinOeB, lineA, lineB;
	int edgesA, e0;
	int failures = 0;
	int checks = 0;
	always #4 clk = ~clk;
	timer8_output_compare_ctc i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .overflowAck, .matchAckA, .matchAckB,
		.overflowIrq, .matchIrqA, .matchIrqB, .pinOutA, .pinOutB, .pinOeA, .pinOeB);
	pin_load i_load (.clk, .pinOut(pinOutA), .pinOe(pinOeA), .line(lineA), .edges(edgesA));
	pin_load i_loadB (.clk, .pinOut(pinOutB), .pinOe(pinOeB), .line(lineB), .edges());
	// ----
	// bus and compare helpers
	// ----
	task automatic wrap_up();
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want)
		begin
			failures++;
			$display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic apb(input logic isWrite, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= isWrite;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no wait limit here: the watchdog ends a hung transfer
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic get(input logic [11:0] a, input logic [31:0] want);
		apb(1'b0, a, 32'h00000000);
		check(rd, want);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		get(timer8_pkg::OFF_CONTROL, 32'h00000000);
		get(timer8_pkg::OFF_PINS, 32'h00000000);
		apb(1'b0, 12'h020, 32'h00000000);
		check({31'h0, err}, 32'h00000001);
	endtask
	task automatic t_normal();
		wr(timer8_pkg::OFF_COUNTER, 32'h000000FD);
		repeat (5) @(posedge clk);
		get(timer8_pkg::OFF_COUNTER, 32'h000000FD);
		pstrb <= 4'hE;
		wr(timer8_pkg::OFF_COUNTER, 32'h00000011);
		pstrb <= 4'hF;
		get(timer8_pkg::OFF_COUNTER, 32'h000000FD);
		wr(timer8_pkg::OFF_IRQ_EN, 32'h00000001);
		wr(timer8_pkg::OFF_CONTROL, 32'h00000010);
		wr(timer8_pkg::OFF_CONTROL, 32'h00000000);
		apb(1'b0, timer8_pkg::OFF_FLAGS, 32'h00000000);
		check(rd & 32'h00000001, 32'h00000001);
		check({31'h0, overflowIrq}, 32'h00000001);
		apb(1'b0, timer8_pkg::OFF_COUNTER, 32'h00000000);
		check({31'h0, rd < 32'h00000010}, 32'h00000001);
		overflowAck <= 1'b1;
		@(posedge clk);
		overflowAck <= 1'b0;
		repeat (2) @(posedge clk);
		check({31'h0, overflowIrq}, 32'h00000000);
		wr(timer8_pkg::OFF_FLAGS, 32'h00000007);
		get(timer8_pkg::OFF_FLAGS, 32'h00000000);
	endtask
	task automatic t_force();
		logic [9:0] act = 10'b0100100011;
		logic [4:0] want = 5'b10011;
		for (int i = 0; i < 5; i++)
		begin
			wr(timer8_pkg::OFF_CONTROL, {22'h0, act[2*i+:2], 8'h00});
			wr(timer8_pkg::OFF_FORCE, 32'h00000001);
			get(timer8_pkg::OFF_PINS, {27'h0, want[i], 4'h0});
			get(timer8_pkg::OFF_FORCE, 32'h00000000);
		end
		get(timer8_pkg::OFF_FLAGS, 32'h00000000);
		wr(timer8_pkg::OFF_PINS, 32'h00000004);
		check({31'h0, lineA}, 32'h00000001);
		wr(timer8_pkg::OFF_PINS, 32'h0000000A);
		check({30'h0, lineB, lineA}, 32'h00000002);
		wr(timer8_pkg::OFF_CONTROL, 32'h00000000);
		wr(timer8_pkg::OFF_PINS, 32'h00000004);
		check({31'h0, lineA}, 32'h00000000);
	endtask
	task automatic t_pwm();
		wr(timer8_pkg::OFF_CONTROL, 32'h00000103);
		wr(timer8_pkg::OFF_FORCE, 32'h00000001);
		get(timer8_pkg::OFF_PINS, 32'h00000014);
		wr(timer8_pkg::OFF_CMP_B, 32'h00000055);
		get(timer8_pkg::OFF_CMP_B, 32'h00000055);
		// stopped, so no top tick ever copied the buffer across
		wr(timer8_pkg::OFF_CONTROL, 32'h00000100);
		get(timer8_pkg::OFF_CMP_B, 32'h00000000);
	endtask
	task automatic t_ctc();
		wr(timer8_pkg::OFF_CONTROL, 32'h00000102);
		get(timer8_pkg::OFF_PINS, 32'h00000014);
		// a start equal to compare A would lose its first match to blocking
		wr(timer8_pkg::OFF_COUNTER, 32'h000000FF);
		wr(timer8_pkg::OFF_CONTROL, 32'h00000112);
		repeat (4) @(posedge clk);
		e0 = edgesA;
		repeat (20) @(posedge clk);
		check(edgesA - e0, 32'd20);
		get(timer8_pkg::OFF_FLAGS, 32'h00000007);
		wr(timer8_pkg::OFF_CMP_A, 32'h00000003);
		e0 = edgesA;
		repeat (40) @(posedge clk);
		check(edgesA - e0, 32'd10);
		repeat (3)
		begin
			apb(1'b0, timer8_pkg::OFF_COUNTER, 32'h00000000);
			check({31'h0, rd <= 32'h00000003}, 32'h00000001);
		end
		wr(timer8_pkg::OFF_CONTROL, 32'h00000102);
		wr(timer8_pkg::OFF_IRQ_EN, 32'h00000006);
		check({30'h0, matchIrqB, matchIrqA}, 32'h00000003);
		matchAckA <= 1'b1;
		matchAckB <= 1'b1;
		@(posedge clk);
		matchAckA <= 1'b0;
		matchAckB <= 1'b0;
		repeat (2) @(posedge clk);
		check({30'h0, matchIrqB, matchIrqA}, 32'h00000000);
	endtask
	initial
	begin
		#40000;
		failures++;
		wrap_up();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_normal();
		t_force();
		t_pwm();
		t_ctc();
		wrap_up();
	end
endmodule // timer8_output_compare_ctc_bench
